//--- rtl/oad_decoder.sv
// Operand addressing decoder and operation executor of an 8-bit CPU.
// Assumes a fetch unit that presents a pre-decoded opcode with its operand
// bytes, and a one-cycle memory read/write port on the same clock.
`timescale 1ns/1ps
`default_nettype none

module oad_decoder (
   // Clock and reset
   input  wire logic              core_clk_in,
   input  wire logic              rst_in,
   // Instruction from fetch unit
   input  wire logic              instr_valid_in,
   input  wire oad_pkg::oad_mode_e mode_in,
   input  wire oad_pkg::oad_op_e  op_in,
   input  wire oad_pkg::oad_tgt_e tgt_in,
   input  wire logic [2:0]        bit_sel_in,
   input  wire logic              branch_cond_in,
   input  wire logic [7:0]        opnd1_in,
   input  wire logic [7:0]        opnd2_in,
   // Memory read data
   input  wire logic [7:0]        mem_rdata_in,
   // Memory bus
   output logic [15:0]            mem_addr_out,
   output logic                   mem_rd_out,
   output logic                   mem_wr_out,
   output logic [7:0]             mem_wdata_out,
   // Status
   output logic                   busy_out,
   output logic [1:0]             instr_len_out,
   output logic [15:0]            pc_out,
   output logic [7:0]             acc_out,
   output logic [7:0]             index_out,
   output logic                   carry_out,
   output logic                   zero_out,
   output logic                   neg_out
);
   typedef enum logic [1:0] {OAD_ST_IDLE, OAD_ST_READ, OAD_ST_EXEC} oad_state_e;

   typedef struct packed {
      oad_state_e         st;
      oad_pkg::oad_op_e   op;
      oad_pkg::oad_tgt_e  tgt;
      logic [2:0]         bsel;
      logic [15:0]        addr;
      logic               rd;
      logic               wr;
      logic [7:0]         wdata;
      logic [1:0]         len;
      logic [15:0]        pc;
      logic [7:0]         acc;
      logic [7:0]         idx;
      logic               c;
      logic               z;
      logic               n;
      logic               busy;
      logic               imm;
   } oad_state_s;

   oad_state_s st_ff;
   oad_state_s nxt_st;

   // Address from mode, operand bytes and index register; length from mode alone
   logic [15:0] ea;
   logic [1:0]  len;
   always_comb begin
      ea  = {oad_pkg::OAD_ZERO_PAGE, opnd1_in};
      len = oad_pkg::OAD_LEN_ONE;
      case (mode_in)
         oad_pkg::OAD_INH: len = oad_pkg::OAD_LEN_ONE;
         oad_pkg::OAD_IMM: len = oad_pkg::OAD_LEN_TWO;
         oad_pkg::OAD_DIR: begin
            len = oad_pkg::OAD_LEN_TWO;
            ea  = {oad_pkg::OAD_ZERO_PAGE, opnd1_in};
         end
         oad_pkg::OAD_EXT: begin
            len = oad_pkg::OAD_LEN_THREE;
            ea  = {opnd1_in, opnd2_in};
         end
         oad_pkg::OAD_IX0: begin
            len = oad_pkg::OAD_LEN_ONE;
            ea  = {oad_pkg::OAD_ZERO_PAGE, st_ff.idx};
         end
         oad_pkg::OAD_IX1: begin
            len = oad_pkg::OAD_LEN_TWO;
            ea  = 16'({oad_pkg::OAD_ZERO_PAGE, st_ff.idx} + {oad_pkg::OAD_ZERO_PAGE, opnd1_in});
         end
         oad_pkg::OAD_IX2: begin
            len = oad_pkg::OAD_LEN_THREE;
            ea  = 16'({opnd1_in, opnd2_in} + {oad_pkg::OAD_ZERO_PAGE, st_ff.idx});
         end
         oad_pkg::OAD_REL: len = oad_pkg::OAD_LEN_TWO;
         default: len = oad_pkg::OAD_LEN_ONE;
      endcase
   end

   // Read-modify-write transform of the fetched value
   logic [7:0] rv;
   logic [7:0] res;
   logic       rc;
   logic [8:0] sum;
   logic [15:0] prod;
   always_comb begin
      // Immediate byte waits in wdata until execute
      rv   = st_ff.imm ? st_ff.wdata :
             (st_ff.tgt == oad_pkg::OAD_TGT_ACC) ? st_ff.acc :
             (st_ff.tgt == oad_pkg::OAD_TGT_IDX) ? st_ff.idx : mem_rdata_in;
      res  = rv;
      rc   = st_ff.c;
      sum  = 9'h000;
      prod = {8'h00, st_ff.acc} * {8'h00, st_ff.idx};
      case (st_ff.op)
         oad_pkg::OAD_OP_SHIFT_LEFT:         {rc, res} = {rv, 1'b0};
         oad_pkg::OAD_OP_ARITH_SHIFT_RIGHT:  begin res = {rv[oad_pkg::OAD_MSB], rv[7:1]}; rc = rv[0]; end
         oad_pkg::OAD_OP_LOGIC_SHIFT_RIGHT:  begin res = {1'b0, rv[7:1]}; rc = rv[0]; end
         oad_pkg::OAD_OP_ROTATE_LEFT_CARRY:  {rc, res} = {rv, st_ff.c};
         oad_pkg::OAD_OP_ROTATE_RIGHT_CARRY: begin res = {st_ff.c, rv[7:1]}; rc = rv[0]; end
         oad_pkg::OAD_OP_ZERO_FILL:          begin res = oad_pkg::OAD_BYTE_ZERO; rc = 1'b0; end
         oad_pkg::OAD_OP_BITWISE_INVERT:     begin res = ~rv; rc = 1'b1; end
         oad_pkg::OAD_OP_ARITH_INVERT:       begin res = 8'(oad_pkg::OAD_BYTE_ZERO - rv); rc = (rv != oad_pkg::OAD_BYTE_ZERO); end
         oad_pkg::OAD_OP_PLUS_ONE:           res = 8'(rv + oad_pkg::OAD_BYTE_ONE);
         oad_pkg::OAD_OP_MINUS_ONE:          res = 8'(rv - oad_pkg::OAD_BYTE_ONE);
         oad_pkg::OAD_OP_SINGLE_BIT_ON:      res = rv | (oad_pkg::OAD_BYTE_ONE << st_ff.bsel);
         oad_pkg::OAD_OP_SINGLE_BIT_OFF:     res = rv & ~(oad_pkg::OAD_BYTE_ONE << st_ff.bsel);
         oad_pkg::OAD_OP_ADD:                begin sum = {1'b0, st_ff.acc} + {1'b0, rv}; res = sum[7:0]; rc = sum[8]; end
         oad_pkg::OAD_OP_ADC:                begin sum = {1'b0, st_ff.acc} + {1'b0, rv} + {8'h00, st_ff.c}; res = sum[7:0]; rc = sum[8]; end
         oad_pkg::OAD_OP_SUB, oad_pkg::OAD_OP_COMPARE_ACC: begin
            sum = {1'b0, st_ff.acc} - {1'b0, rv}; res = sum[7:0]; rc = sum[8];
         end
         oad_pkg::OAD_OP_MINUS_WITH_BORROW:  begin sum = {1'b0, st_ff.acc} - {1'b0, rv} - {8'h00, st_ff.c}; res = sum[7:0]; rc = sum[8]; end
         oad_pkg::OAD_OP_COMPARE_INDEX:      begin sum = {1'b0, st_ff.idx} - {1'b0, rv}; res = sum[7:0]; rc = sum[8]; end
         oad_pkg::OAD_OP_AND, oad_pkg::OAD_OP_BIT: res = st_ff.acc & rv;
         oad_pkg::OAD_OP_OR_ACC:             res = st_ff.acc | rv;
         oad_pkg::OAD_OP_XOR_ACC:            res = st_ff.acc ^ rv;
         default:                            res = rv;
      endcase
   end

   // Sequencer: idle, memory read, execute and write back
   always_comb begin
      nxt_st    = st_ff;
      nxt_st.rd = 1'b0;
      nxt_st.wr = 1'b0;
      case (st_ff.st)
         OAD_ST_IDLE: begin
            if (instr_valid_in) begin
               nxt_st.len  = len;
               nxt_st.imm  = (mode_in == oad_pkg::OAD_IMM);
               nxt_st.pc   = 16'(st_ff.pc + {14'h0000, len});
               nxt_st.op   = op_in;
               nxt_st.bsel = bit_sel_in;
               nxt_st.addr = ea;
               nxt_st.tgt  = (mode_in == oad_pkg::OAD_INH) ? tgt_in : oad_pkg::OAD_TGT_MEM;
               if ((op_in == oad_pkg::OAD_OP_SINGLE_BIT_ON || op_in == oad_pkg::OAD_OP_SINGLE_BIT_OFF) &&
                   mode_in != oad_pkg::OAD_DIR) begin
                  nxt_st.op = oad_pkg::OAD_OP_NONE;
               end else if (op_in == oad_pkg::OAD_OP_BRANCH) begin
                  if (mode_in == oad_pkg::OAD_REL && branch_cond_in)
                     nxt_st.pc = 16'(st_ff.pc + {14'h0000, len} + {{8{opnd1_in[oad_pkg::OAD_MSB]}}, opnd1_in});
               end else if (op_in == oad_pkg::OAD_OP_UNSIGNED_PRODUCT) begin
                  nxt_st.st = OAD_ST_EXEC;
               end else if (op_in == oad_pkg::OAD_OP_STORE_ACC || op_in == oad_pkg::OAD_OP_STORE_INDEX) begin
                  nxt_st.wr    = 1'b1;
                  nxt_st.wdata = (op_in == oad_pkg::OAD_OP_STORE_ACC) ? st_ff.acc : st_ff.idx;
                  nxt_st.z     = ((op_in == oad_pkg::OAD_OP_STORE_ACC) ? st_ff.acc : st_ff.idx) == oad_pkg::OAD_BYTE_ZERO;
               end else if (mode_in == oad_pkg::OAD_IMM) begin
                  nxt_st.tgt = oad_pkg::OAD_TGT_ACC;
                  nxt_st.st  = OAD_ST_EXEC;
               end else if (op_in != oad_pkg::OAD_OP_NONE) begin
                  nxt_st.rd = (mode_in != oad_pkg::OAD_INH);
                  nxt_st.st = OAD_ST_READ;
               end
               if (mode_in == oad_pkg::OAD_IMM) begin
                  nxt_st.wdata = opnd1_in;
               end
            end
         end
         OAD_ST_READ: nxt_st.st = OAD_ST_EXEC;
         OAD_ST_EXEC: begin
            nxt_st.st = OAD_ST_IDLE;
            nxt_st.c  = rc;
            nxt_st.z  = (res == oad_pkg::OAD_BYTE_ZERO);
            nxt_st.n  = res[oad_pkg::OAD_MSB];
            case (st_ff.op)
               oad_pkg::OAD_OP_UNSIGNED_PRODUCT: begin
                  nxt_st.idx = prod[15:8];
                  nxt_st.acc = prod[7:0];
                  nxt_st.c   = 1'b0;
               end
               oad_pkg::OAD_OP_LOAD_ACC:   nxt_st.acc = rv;
               oad_pkg::OAD_OP_LOAD_INDEX: nxt_st.idx = rv;
               oad_pkg::OAD_OP_ADD, oad_pkg::OAD_OP_ADC, oad_pkg::OAD_OP_SUB,
               oad_pkg::OAD_OP_MINUS_WITH_BORROW, oad_pkg::OAD_OP_AND,
               oad_pkg::OAD_OP_OR_ACC, oad_pkg::OAD_OP_XOR_ACC: nxt_st.acc = res;
               oad_pkg::OAD_OP_BIT, oad_pkg::OAD_OP_COMPARE_ACC, oad_pkg::OAD_OP_COMPARE_INDEX,
               oad_pkg::OAD_OP_FLAG_TEST_ONLY: ;
               default: begin
                  // Write back to the same register or location
                  if (st_ff.tgt == oad_pkg::OAD_TGT_ACC)      nxt_st.acc = res;
                  else if (st_ff.tgt == oad_pkg::OAD_TGT_IDX) nxt_st.idx = res;
                  else begin
                     nxt_st.wr    = 1'b1;
                     nxt_st.wdata = res;
                  end
               end
            endcase
         end
         default: nxt_st.st = OAD_ST_IDLE;
      endcase
      // Busy held in its own flop
      nxt_st.busy = (nxt_st.st != OAD_ST_IDLE);
   end

   // State register
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         st_ff    <= '0;
         st_ff.pc <= oad_pkg::OAD_RST_PC;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // Outputs straight from flops
   assign mem_addr_out  = st_ff.addr;
   assign mem_rd_out    = st_ff.rd;
   assign mem_wr_out    = st_ff.wr;
   assign mem_wdata_out = st_ff.wdata;
   assign busy_out      = st_ff.busy;
   assign instr_len_out = st_ff.len;
   assign pc_out        = st_ff.pc;
   assign acc_out       = st_ff.acc;
   assign index_out     = st_ff.idx;
   assign carry_out     = st_ff.c;
   assign zero_out      = st_ff.z;
   assign neg_out       = st_ff.n;

   // Assertions
   sequence s_rmw_start;
      !busy_out && instr_valid_in && op_in == oad_pkg::OAD_OP_FLAG_TEST_ONLY && mode_in == oad_pkg::OAD_DIR;
   endsequence
   AST_TEST_NO_WRITE: assert property (@(posedge core_clk_in) disable iff (rst_in)
      s_rmw_start |=> !mem_wr_out [*3]) else $error("flag test wrote memory");
   AST_DIR_ADDR: assert property (@(posedge core_clk_in) disable iff (rst_in)
      !busy_out && instr_valid_in && mode_in == oad_pkg::OAD_DIR |=> mem_addr_out == {8'h00, $past(opnd1_in)})
      else $error("direct address wrong");
   AST_EXT_LEN: assert property (@(posedge core_clk_in) disable iff (rst_in)
      !busy_out && instr_valid_in && mode_in == oad_pkg::OAD_EXT && op_in != oad_pkg::OAD_OP_BRANCH |=>
      pc_out == 16'($past(pc_out) + 16'h0003)) else $error("extended length wrong");
   AST_INH_LEN: assert property (@(posedge core_clk_in) disable iff (rst_in)
      !busy_out && instr_valid_in && mode_in == oad_pkg::OAD_INH |=> instr_len_out == 2'h1 && !mem_rd_out)
      else $error("inherent length wrong");
   AST_IX0_ADDR: assert property (@(posedge core_clk_in) disable iff (rst_in)
      !busy_out && instr_valid_in && mode_in == oad_pkg::OAD_IX0 |=> mem_addr_out[15:8] == 8'h00)
      else $error("indexed page wrong");
   AST_IX1_ADDR: assert property (@(posedge core_clk_in) disable iff (rst_in)
      !busy_out && instr_valid_in && mode_in == oad_pkg::OAD_IX1 |=>
      mem_addr_out == 16'({8'h00, $past(index_out)} + {8'h00, $past(opnd1_in)})) else $error("ix1 address wrong");
   AST_MUL: assert property (@(posedge core_clk_in) disable iff (rst_in)
      !busy_out && instr_valid_in && op_in == oad_pkg::OAD_OP_UNSIGNED_PRODUCT |=> ##1
      {index_out, acc_out} == {8'h00, $past(acc_out, 2)} * {8'h00, $past(index_out, 2)})
      else $error("multiply wrong");
   AST_BIT_DIR: assert property (@(posedge core_clk_in) disable iff (rst_in)
      !busy_out && instr_valid_in && mode_in != oad_pkg::OAD_DIR &&
      (op_in == oad_pkg::OAD_OP_SINGLE_BIT_ON || op_in == oad_pkg::OAD_OP_SINGLE_BIT_OFF)
      |=> !busy_out && !mem_rd_out && !mem_wr_out) else $error("bit op outside direct");
endmodule // oad_decoder

`default_nettype wire

//--- rtl/oad_pkg.sv
// Constants shared by the operand addressing decoder.
// Assumes an 8-bit CPU core with a 16-bit address bus.
package oad_pkg;
   // Addressing modes decoded from the opcode
   typedef enum logic [2:0] {
      OAD_INH, OAD_IMM, OAD_DIR, OAD_EXT, OAD_IX0, OAD_IX1, OAD_IX2, OAD_REL
   } oad_mode_e;
   // Operation classes
   typedef enum logic [4:0] {
      OAD_OP_NONE, OAD_OP_LOAD_ACC, OAD_OP_LOAD_INDEX, OAD_OP_STORE_ACC, OAD_OP_STORE_INDEX,
      OAD_OP_ADD, OAD_OP_ADC, OAD_OP_SUB, OAD_OP_MINUS_WITH_BORROW, OAD_OP_AND, OAD_OP_OR_ACC,
      OAD_OP_XOR_ACC, OAD_OP_BIT, OAD_OP_COMPARE_ACC, OAD_OP_COMPARE_INDEX, OAD_OP_UNSIGNED_PRODUCT,
      OAD_OP_SHIFT_LEFT, OAD_OP_ARITH_SHIFT_RIGHT, OAD_OP_LOGIC_SHIFT_RIGHT, OAD_OP_ROTATE_LEFT_CARRY,
      OAD_OP_ROTATE_RIGHT_CARRY, OAD_OP_ZERO_FILL, OAD_OP_BITWISE_INVERT, OAD_OP_ARITH_INVERT,
      OAD_OP_PLUS_ONE, OAD_OP_MINUS_ONE, OAD_OP_FLAG_TEST_ONLY, OAD_OP_SINGLE_BIT_ON,
      OAD_OP_SINGLE_BIT_OFF, OAD_OP_BRANCH
   } oad_op_e;
   // Operand target of a read-modify-write
   typedef enum logic [1:0] {OAD_TGT_MEM, OAD_TGT_ACC, OAD_TGT_IDX} oad_tgt_e;
   // Instruction lengths in bytes
   localparam logic [1:0] OAD_LEN_ONE   = 2'h1;
   localparam logic [1:0] OAD_LEN_TWO   = 2'h2;
   localparam logic [1:0] OAD_LEN_THREE = 2'h3;
   // Fixed values
   localparam logic [7:0]  OAD_ZERO_PAGE = 8'h00;
   localparam logic [7:0]  OAD_BYTE_ZERO = 8'h00;
   localparam logic [7:0]  OAD_BYTE_ONE  = 8'h01;
   localparam logic [15:0] OAD_RST_PC    = 16'h0000;
   localparam int          OAD_MSB       = 7;
endpackage : oad_pkg

//--- tb/oad_mem_model.sv
// Memory on the far side of the decoder's bus.
// Assumes one-cycle read and write pulses on the decoder's clock.
`timescale 1ns/1ps
`default_nettype none
module oad_mem_model (
   // Clock
   input  wire logic        core_clk_in,
   // Bus from the decoder
   input  wire logic [15:0] mem_addr_in,
   input  wire logic        mem_rd_in,
   input  wire logic        mem_wr_in,
   input  wire logic [7:0]  mem_wdata_in,
   // Read data back
   output logic [7:0]       mem_rdata_out
);
   logic [7:0] mem [0:65535];
   // Data valid the cycle after a read, a changing pattern otherwise
   initial mem_rdata_out = 8'h5a;
   always @(posedge core_clk_in) begin
      if (mem_rd_in) mem_rdata_out <= mem[mem_addr_in];
      else mem_rdata_out <= ~mem_rdata_out;
      if (mem_wr_in) mem[mem_addr_in] <= mem_wdata_in;
   end
endmodule // oad_mem_model
`default_nettype wire

//--- tb/oad_decoder_bench.sv
// Bench for the decoder: drives instructions, notes expected bus events in
// a queue and checks them and the registers against its own model.
// Assumes the memory model answers every read the cycle after.
`timescale 1ns/1ps
`default_nettype none
module oad_decoder_bench;
   logic               core_clk_in, rst_in, instr_valid_in, branch_cond_in;
   oad_pkg::oad_mode_e mode_in;
   oad_pkg::oad_op_e   op_in;
   oad_pkg::oad_tgt_e  tgt_in;
   logic [2:0]         bit_sel_in;
   logic [7:0]         opnd1_in, opnd2_in, mem_rdata_in, mem_wdata_out, acc_out, index_out, ax, xx, v, r1, r2;
   logic [15:0]        mem_addr_out, pc_out, pc;
   logic [1:0]         instr_len_out;
   logic               mem_rd_out, mem_wr_out, busy_out, carry_out, zero_out, neg_out, cy;
   logic [24:0]        exq[$];
   int                 num_errors, checked, i;
   oad_pkg::oad_op_e   rm[7] = '{oad_pkg::OAD_OP_ADD, oad_pkg::OAD_OP_ADC, oad_pkg::OAD_OP_SUB,
      oad_pkg::OAD_OP_MINUS_WITH_BORROW, oad_pkg::OAD_OP_AND, oad_pkg::OAD_OP_OR_ACC, oad_pkg::OAD_OP_XOR_ACC};
   oad_pkg::oad_op_e   rw[10] = '{oad_pkg::OAD_OP_SHIFT_LEFT, oad_pkg::OAD_OP_ARITH_SHIFT_RIGHT,
      oad_pkg::OAD_OP_LOGIC_SHIFT_RIGHT, oad_pkg::OAD_OP_ROTATE_LEFT_CARRY, oad_pkg::OAD_OP_ROTATE_RIGHT_CARRY,
      oad_pkg::OAD_OP_PLUS_ONE, oad_pkg::OAD_OP_MINUS_ONE, oad_pkg::OAD_OP_BITWISE_INVERT,
      oad_pkg::OAD_OP_ARITH_INVERT, oad_pkg::OAD_OP_ZERO_FILL};
   // Design and memory
   oad_decoder i_dut (.core_clk_in, .rst_in, .instr_valid_in, .mode_in, .op_in, .tgt_in, .bit_sel_in,
      .branch_cond_in, .opnd1_in, .opnd2_in, .mem_rdata_in, .mem_addr_out, .mem_rd_out, .mem_wr_out,
      .mem_wdata_out, .busy_out, .instr_len_out, .pc_out, .acc_out, .index_out, .carry_out, .zero_out, .neg_out);
   oad_mem_model i_mem (.core_clk_in, .mem_addr_in(mem_addr_out), .mem_rd_in(mem_rd_out),
      .mem_wr_in(mem_wr_out), .mem_wdata_in(mem_wdata_out), .mem_rdata_out(mem_rdata_in));
   // Clock
   initial begin
      core_clk_in = 1'b0;
      forever #10 core_clk_in = ~core_clk_in;
   end
   task automatic conclude();
      $display("errors %0d checks %0d", num_errors, checked);
      if (num_errors == 0 && checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic check_bus(input logic [24:0] got, input logic [24:0] exp);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected bus event at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic check_reg(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic ex(input logic w, input logic [15:0] a, input logic [7:0] d);
      exq.push_back({w, a, w ? d : 8'h00});
   endtask
   // Model of the result and carry of each operation in rm and rw
   function automatic logic [7:0] alu(input oad_pkg::oad_op_e o, input logic [7:0] d);
      logic [8:0] s;
      case (o)
         oad_pkg::OAD_OP_SHIFT_LEFT:          s = {d, 1'b0};
         oad_pkg::OAD_OP_ARITH_SHIFT_RIGHT:   s = {d[0], d[7], d[7:1]};
         oad_pkg::OAD_OP_LOGIC_SHIFT_RIGHT:   s = {d[0], 1'b0, d[7:1]};
         oad_pkg::OAD_OP_ROTATE_LEFT_CARRY:   s = {d, cy};
         oad_pkg::OAD_OP_ROTATE_RIGHT_CARRY:  s = {d[0], cy, d[7:1]};
         oad_pkg::OAD_OP_PLUS_ONE:            s = {cy, d + 8'h01};
         oad_pkg::OAD_OP_MINUS_ONE:           s = {cy, d - 8'h01};
         oad_pkg::OAD_OP_BITWISE_INVERT:      s = {1'b1, ~d};
         oad_pkg::OAD_OP_ARITH_INVERT:        s = {d != 8'h00, 8'h00 - d};
         oad_pkg::OAD_OP_ZERO_FILL:           s = {1'b0, 8'h00};
         oad_pkg::OAD_OP_ADD:                 s = {1'b0, ax} + {1'b0, d};
         oad_pkg::OAD_OP_ADC:                 s = {1'b0, ax} + {1'b0, d} + {8'h00, cy};
         oad_pkg::OAD_OP_SUB:                 s = {1'b0, ax} - {1'b0, d};
         oad_pkg::OAD_OP_MINUS_WITH_BORROW:   s = {1'b0, ax} - {1'b0, d} - {8'h00, cy};
         oad_pkg::OAD_OP_AND:                 s = {cy, ax & d};
         oad_pkg::OAD_OP_OR_ACC:              s = {cy, ax | d};
         oad_pkg::OAD_OP_XOR_ACC:             s = {cy, ax ^ d};
         default:                             s = {cy, d};
      endcase
      cy = s[8];
      return s[7:0];
   endfunction
   // One instruction: present it for one edge, wait for idle, check length and pc
   task automatic run(input oad_pkg::oad_mode_e m, input oad_pkg::oad_op_e o, input oad_pkg::oad_tgt_e t,
                      input logic [7:0] a, input logic [7:0] b, input logic c);
      int n;
      logic [1:0] ln;
      n = 0;
      ln = (m == oad_pkg::OAD_INH || m == oad_pkg::OAD_IX0) ? oad_pkg::OAD_LEN_ONE :
           (m == oad_pkg::OAD_EXT || m == oad_pkg::OAD_IX2) ? oad_pkg::OAD_LEN_THREE : oad_pkg::OAD_LEN_TWO;
      mode_in = m;
      op_in = o;
      tgt_in = t;
      opnd1_in = a;
      opnd2_in = b;
      bit_sel_in = b[2:0];
      branch_cond_in = c;
      instr_valid_in = 1'b1;
      do begin
         @(posedge core_clk_in);
         #1;
         instr_valid_in = 1'b0;
         n++;
      end while (busy_out !== 1'b0 && n < 20);
      // One idle edge so the next request starts in a later time step
      @(posedge core_clk_in);
      #1;
      if (n >= 20) begin
         num_errors++;
         conclude();
      end
      pc = pc + 16'(ln);
      if (m == oad_pkg::OAD_REL && c) pc = pc + {{8{a[7]}}, a};
      check_reg(16'(instr_len_out), 16'(ln));
      check_reg(pc_out, pc);
   endtask
   task automatic rd(input oad_pkg::oad_mode_e m, input oad_pkg::oad_op_e o, input logic [15:0] ad,
                     input logic [7:0] a, input logic [7:0] b, input logic [7:0] d);
      i_mem.mem[ad] = d;
      ex(1'b0, ad, 8'h00);
      run(m, o, oad_pkg::OAD_TGT_MEM, a, b, 1'b0);
   endtask
   // Take the oldest note whenever the bus shows a read or a write
   always @(posedge core_clk_in) begin
      if (rst_in !== 1'b1 && (mem_rd_out === 1'b1 || mem_wr_out === 1'b1)) begin
         if (exq.size() == 0) check_bus({mem_wr_out, mem_addr_out, mem_wdata_out}, 25'h1ff_ffff);
         else check_bus({mem_wr_out, mem_addr_out, mem_wr_out ? mem_wdata_out : 8'h00}, exq.pop_front());
      end
   end
   // Main sequence
   initial begin
      {rst_in, instr_valid_in, branch_cond_in, bit_sel_in, opnd1_in, opnd2_in} = {1'b1, 21'h0};
      mode_in = oad_pkg::OAD_INH;
      op_in = oad_pkg::OAD_OP_NONE;
      tgt_in = oad_pkg::OAD_TGT_MEM;
      {num_errors, checked, pc, ax, xx, cy} = '0;
      void'($urandom(32'h8920));
      repeat (8) @(posedge core_clk_in);
      #1 rst_in = 1'b0;
      check_reg({index_out, acc_out}, 16'h0000);
      {r1, r2, v} = 24'($urandom);
      rd(oad_pkg::OAD_DIR, oad_pkg::OAD_OP_LOAD_ACC, {8'h00, r1}, r1, r2, v);
      ax = v;
      {r1, r2, v} = 24'($urandom);
      rd(oad_pkg::OAD_EXT, oad_pkg::OAD_OP_LOAD_INDEX, {r1, r2}, r1, r2, v);
      xx = v;
      run(oad_pkg::OAD_INH, oad_pkg::OAD_OP_UNSIGNED_PRODUCT, oad_pkg::OAD_TGT_ACC, 8'h00, 8'h00, 1'b0);
      {xx, ax} = ax * xx;
      cy = 1'b0;
      check_reg({index_out, acc_out}, {xx, ax});
      for (i = 0; i < 7; i++) begin
         {r1, v} = 16'($urandom);
         rd(oad_pkg::OAD_IX1, rm[i], 16'(xx) + 16'(r1), r1, 8'h00, v);
         ax = alu(rm[i], v);
         check_reg(16'({carry_out, acc_out}), 16'({cy, ax}));
      end
      v = 8'($urandom);
      rd(oad_pkg::OAD_IX0, oad_pkg::OAD_OP_LOAD_INDEX, {8'h00, xx}, 8'h00, 8'h00, v);
      xx = v;
      {r1, r2} = 16'($urandom);
      ex(1'b1, {r1, r2} + 16'(xx), ax);
      run(oad_pkg::OAD_IX2, oad_pkg::OAD_OP_STORE_ACC, oad_pkg::OAD_TGT_MEM, r1, r2, 1'b0);
      r1 = 8'($urandom);
      ex(1'b1, {8'h00, r1}, xx);
      run(oad_pkg::OAD_DIR, oad_pkg::OAD_OP_STORE_INDEX, oad_pkg::OAD_TGT_MEM, r1, 8'h00, 1'b0);
      // Read-modify-write only on plain memory, never a write-only place
      for (i = 0; i < 10; i++) begin
         {r1, v} = 16'($urandom);
         i_mem.mem[{8'h00, r1}] = v;
         ex(1'b0, {8'h00, r1}, 8'h00);
         ex(1'b1, {8'h00, r1}, alu(rw[i], v));
         run(oad_pkg::OAD_DIR, rw[i], oad_pkg::OAD_TGT_MEM, r1, 8'h00, 1'b0);
         check_reg(16'(carry_out), 16'(cy));
      end
      r1 = 8'($urandom);
      rd(oad_pkg::OAD_DIR, oad_pkg::OAD_OP_FLAG_TEST_ONLY, {8'h00, r1}, r1, 8'h00, 8'h80);
      check_reg(16'({zero_out, neg_out}), 16'h0001);
      {r1, r2, v} = 24'($urandom);
      i_mem.mem[{8'h00, r1}] = v;
      ex(1'b0, {8'h00, r1}, 8'h00);
      ex(1'b1, {8'h00, r1}, v | (8'h01 << r2[2:0]));
      run(oad_pkg::OAD_DIR, oad_pkg::OAD_OP_SINGLE_BIT_ON, oad_pkg::OAD_TGT_MEM, r1, r2, 1'b0);
      run(oad_pkg::OAD_EXT, oad_pkg::OAD_OP_SINGLE_BIT_OFF, oad_pkg::OAD_TGT_MEM, r1, r2, 1'b0);
      run(oad_pkg::OAD_INH, oad_pkg::OAD_OP_PLUS_ONE, oad_pkg::OAD_TGT_ACC, 8'h00, 8'h00, 1'b0);
      run(oad_pkg::OAD_INH, oad_pkg::OAD_OP_MINUS_ONE, oad_pkg::OAD_TGT_IDX, 8'h00, 8'h00, 1'b0);
      check_reg({index_out, acc_out}, {xx - 8'h01, ax + 8'h01});
      xx = xx - 8'h01;
      r1 = 8'($urandom);
      run(oad_pkg::OAD_IMM, oad_pkg::OAD_OP_LOAD_ACC, oad_pkg::OAD_TGT_ACC, r1, 8'h00, 1'b0);
      check_reg(16'(acc_out), 16'(r1));
      // Immediate compares and bit test change flags only
      r2 = 8'($urandom);
      run(oad_pkg::OAD_IMM, oad_pkg::OAD_OP_COMPARE_ACC, oad_pkg::OAD_TGT_ACC, r2, 8'h00, 1'b0);
      check_reg({7'h00, carry_out, acc_out}, {7'h00, r1 < r2, r1});
      run(oad_pkg::OAD_IMM, oad_pkg::OAD_OP_COMPARE_INDEX, oad_pkg::OAD_TGT_ACC, r2, 8'h00, 1'b0);
      check_reg({7'h00, carry_out, index_out}, {7'h00, xx < r2, xx});
      run(oad_pkg::OAD_IMM, oad_pkg::OAD_OP_BIT, oad_pkg::OAD_TGT_ACC, r2, 8'h00, 1'b0);
      check_reg({7'h00, zero_out, acc_out}, {7'h00, (r1 & r2) == 8'h00, r1});
      for (i = 0; i < 4; i++) begin
         r1 = 8'($urandom);
         run(oad_pkg::OAD_REL, oad_pkg::OAD_OP_BRANCH, oad_pkg::OAD_TGT_MEM, r1, 8'h00, i[0]);
      end
      repeat (4) @(posedge core_clk_in);
      check_reg(16'(exq.size()), 16'h0000);
      conclude();
   end
endmodule // oad_decoder_bench
`default_nettype wire
